// ==== core/reset_supply_monitor.sv ====
// Purpose: Reset sequencer and supply monitor for a small controller.
// Assumes: Supply comparators and the reset pin are asynchronous.
// Notes: RAM is never touched here; the core reset, the reset pin, the port defaults, flash gating and status outputs are driven.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module reset_supply_monitor
	import reset_supply_monitor_pkg::*;
#(
	parameter int POR_DELAY_CYCLES = POR_CYCLES,
	parameter int HOLD_LEN = HOLD_CYCLES,
	parameter bit FLASH_ERR_RESET = 1'b0
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire reg_req_t i_reg,
	output logic [7:0] o_rdata,
	input wire logic i_rst_pin_b,
	input wire logic i_vdd_above_por,
	input wire logic i_vdd_above_rst,
	input wire logic i_vdd_above_warn,
	input wire src_req_t i_src,
	input wire logic i_sleep,
	input wire logic i_flash_cmd,
	output logic o_flash_go,
	output logic o_core_rst,
	output logic o_rst_pin_out,
	output logic o_rst_pin_oe,
	output port_init_t o_port,
	output logic o_exit_pulse,
	output logic [15:0] o_boot_addr,
	output logic o_warn_irq,
	output logic o_ram_lost
);

	typedef struct packed {
		rst_state_t st;
		logic [CNT_W-1:0] cnt;
		logic [3:0] s1;
		logic [3:0] s2;
		logic [7:0] flags;
		logic mon_en;
		logic mon_sel;
		logic rtc_en;
		logic warn_ie;
		logic core_rst;
		logic pin_oe;
		logic [1:0] oe_hist;
		port_init_t port;
		logic exit_p;
		logic flash_go;
		logic warn_irq;
		logic ram_lost;
		logic [7:0] rdata;
	} state_t;

	localparam port_init_t PORT_RST = '{
		hold: 1'b1,
		latch: PORT_LATCH_RST,
		push_pull: 1'b0,
		high_drive: 1'b0,
		pullup_en: 1'b1
	};

	localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_DELAY_CYCLES - 1);
	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_LEN - 1);

	state_t r;
	state_t n;
	logic mon_act;
	logic por_req;
	logic pf_req;
	logic sw_req;
	logic flash_bad;
	logic other_req;
	logic wr_ok;
	logic enter_pwr;
	logic enter_hold;
	logic release_rst;
	logic [7:0] cause_set;

	// Request decode from synchronised levels and same-clock sources.
	always_comb begin
		wr_ok = i_reg.wr && (r.st == ST_RUN);
		// Sleep hides the monitor without losing the software copy.
		mon_act = r.mon_en && r.mon_sel && !i_sleep;
		por_req = !r.s2[S_POR];
		pf_req = mon_act && !r.s2[S_RST];
		sw_req = wr_ok && (i_reg.addr == CAUSE_ADDR) && i_reg.wdata[B_SW];
		// Flash work is refused while the monitor is off.
		flash_bad = i_flash_cmd && !r.mon_en && FLASH_ERR_RESET;
		cause_set = 8'h00;
		// Our own drive echoes through the pin synchroniser, so the pin counts only once it has settled.
		cause_set[B_PIN] = !r.s2[S_PIN] && !(|r.oe_hist);
		cause_set[B_MCD] = i_src.mcd;
		cause_set[B_WDT] = i_src.wdt;
		cause_set[B_SW] = sw_req;
		cause_set[B_FERR] = i_src.flash_err || flash_bad;
		cause_set[B_RTC] = i_src.rtc && r.rtc_en;
		other_req = |cause_set;
	end

	// Next-state logic for the whole block.
	always_comb begin
		n = r;
		n.s1 = {i_vdd_above_warn, i_vdd_above_rst, i_vdd_above_por, i_rst_pin_b};
		n.s2 = r.s1;
		n.exit_p = 1'b0;
		n.flash_go = 1'b0;
		n.rdata = 8'h00;
		enter_pwr = 1'b0;
		enter_hold = 1'b0;
		release_rst = 1'b0;
		case (r.st)
			ST_POWER_UP: begin
				n.cnt = '0;
				// Leave only once the supply is above the reset threshold.
				if (r.s2[S_POR] && r.s2[S_RST]) begin
					n.st = ST_POR_DELAY;
				end
			end
			ST_POR_DELAY: begin
				if (!r.s2[S_POR] || !r.s2[S_RST]) begin
					n.st = ST_POWER_UP;
					n.cnt = '0;
				end else if (r.cnt == POR_LAST) begin
					release_rst = 1'b1;
				end else begin
					n.cnt = r.cnt + 1'b1;
				end
			end
			ST_RUN: begin
				if (por_req) begin
					enter_pwr = 1'b1;
					n.st = ST_POWER_UP;
				end else if (pf_req) begin
					enter_pwr = 1'b1;
					n.st = ST_SUPPLY_FAIL;
				end else if (other_req) begin
					enter_hold = 1'b1;
				end
			end
			ST_SUPPLY_FAIL: begin
				if (por_req) begin
					n.st = ST_POWER_UP;
				end else if (r.s2[S_RST]) begin
					release_rst = 1'b1;
				end
			end
			ST_HOLD: begin
				if (por_req) begin
					enter_pwr = 1'b1;
					n.st = ST_POWER_UP;
				end else if (pf_req) begin
					enter_pwr = 1'b1;
					n.st = ST_SUPPLY_FAIL;
				end else if (!r.s2[S_PIN]) begin
					// An external hold keeps the counter at zero.
					n.cnt = '0;
				end else if (r.cnt == HOLD_LAST) begin
					release_rst = 1'b1;
				end else begin
					n.cnt = r.cnt + 1'b1;
				end
			end
			default: begin
				enter_pwr = 1'b1;
				n.st = ST_POWER_UP;
			end
		endcase

		// Supply resets report only the power-on cause.
		if (enter_pwr) begin
			n.flags = FLAGS_RST;
			n.mon_en = 1'b1;
			n.mon_sel = 1'b1;
			n.cnt = '0;
		end

		// Other causes clear the power-on flag and keep monitor state.
		if (enter_hold) begin
			n.flags = cause_set;
			n.st = ST_HOLD;
			n.cnt = '0;
		end

		// Every reset entry clears the RTC enable and the warning interrupt enable.
		if (enter_pwr || enter_hold) begin
			n.rtc_en = 1'b0;
			n.warn_ie = 1'b0;
		end

		// Release lands in run and fetches from the boot address.
		if (release_rst) begin
			n.st = ST_RUN;
			n.cnt = '0;
			n.exit_p = 1'b1;
		end

		// Register writes act only while the core runs.
		if (wr_ok && !enter_pwr && !enter_hold) begin
			if (i_reg.addr == CAUSE_ADDR) begin
				n.mon_sel = i_reg.wdata[B_POR];
				n.rtc_en = i_reg.wdata[B_RTC];
			end
			if (i_reg.addr == MON_ADDR) begin
				n.mon_en = i_reg.wdata[M_EN];
				n.warn_ie = i_reg.wdata[M_IE];
			end
		end

		// Read data stands only in the cycle after the strobe.
		if (i_reg.rd) begin
			if (i_reg.addr == CAUSE_ADDR) begin
				n.rdata = r.flags;
			end else if (i_reg.addr == MON_ADDR) begin
				n.rdata[M_EN] = r.mon_en;
				n.rdata[M_OK] = r.s2[S_WARN];
				n.rdata[M_SEL] = r.mon_sel;
				n.rdata[M_IE] = r.warn_ie;
			end
		end

		// Flash commands pass only with the monitor on.
		n.flash_go = i_flash_cmd && r.mon_en && (r.st == ST_RUN);

		// Early warning as a level interrupt.
		n.warn_irq = r.warn_ie && !r.s2[S_WARN];

		// Core reset halts execution and resets the stack pointer.
		n.core_rst = (n.st != ST_RUN);
		n.pin_oe = (n.st == ST_POWER_UP) || (n.st == ST_POR_DELAY) || (n.st == ST_SUPPLY_FAIL);
		// Two cycles of drive history cover the synchroniser latency of the pin.
		n.oe_hist = {r.oe_hist[0], r.pin_oe};
		n.port = PORT_RST;
		n.port.hold = n.core_rst;
		n.ram_lost = n.flags[B_POR];
	end

	// State register.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '{
				st: ST_POWER_UP,
				cnt: '0,
				s1: SYNC_RST,
				s2: SYNC_RST,
				flags: FLAGS_RST,
				mon_en: 1'b1,
				mon_sel: 1'b1,
				rtc_en: 1'b0,
				warn_ie: 1'b0,
				core_rst: 1'b1,
				pin_oe: 1'b1,
				oe_hist: 2'h3,
				port: PORT_RST,
				exit_p: 1'b0,
				flash_go: 1'b0,
				warn_irq: 1'b0,
				ram_lost: 1'b1,
				rdata: 8'h00
			};
		end else begin
			r <= n;
		end
	end

	// Outputs straight from the state register, except the constant pin level and boot address.
	assign o_rdata = r.rdata;
	assign o_flash_go = r.flash_go;
	assign o_core_rst = r.core_rst;
	assign o_rst_pin_out = 1'b0;
	assign o_rst_pin_oe = r.pin_oe;
	assign o_port = r.port;
	assign o_exit_pulse = r.exit_p;
	assign o_boot_addr = BOOT_ADDR;
	assign o_warn_irq = r.warn_irq;
	assign o_ram_lost = r.ram_lost;

	// Checks on the sequencing.
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	property p_port_init;
		o_core_rst |-> o_port.hold && o_port.latch == PORT_LATCH_RST && o_port.pullup_en && !o_port.push_pull;
	endproperty
	a_port_init: assert property (p_port_init) else $error("Port defaults wrong in reset.");

	property p_pin_low;
		(r.st == ST_SUPPLY_FAIL || r.st == ST_POWER_UP) |-> o_rst_pin_oe && !o_rst_pin_out && o_core_rst;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("Reset pin not driven low.");

	property p_exit;
		o_exit_pulse |-> !o_core_rst && o_boot_addr == BOOT_ADDR ##1 !o_exit_pulse;
	endproperty
	a_exit: assert property (p_exit) else $error("Bad exit from reset.");

	property p_por_gate;
		(r.st == ST_POR_DELAY && !r.s2[S_RST]) |=> r.st == ST_POWER_UP ##1 o_core_rst;
	endproperty
	a_por_gate: assert property (p_por_gate) else $error("Released below threshold.");

	property p_por_delay;
		($past(r.st) == ST_POR_DELAY && r.st == ST_RUN) |-> $past(r.cnt) == POR_LAST;
	endproperty
	a_por_delay: assert property (p_por_delay) else $error("Power-on delay wrong.");

	property p_por_flag;
		($past(r.st) == ST_POR_DELAY && r.st == ST_RUN) |-> r.flags[B_POR] && o_ram_lost;
	endproperty
	a_por_flag: assert property (p_por_flag) else $error("Power-on flag not set.");

	property p_other_clear;
		(r.st == ST_RUN && enter_hold) |=> !r.flags[B_POR] && r.st == ST_HOLD;
	endproperty
	a_other_clear: assert property (p_other_clear) else $error("Power-on flag not cleared.");

	property p_force_mon;
		(r.st == ST_SUPPLY_FAIL) |-> r.mon_en && r.mon_sel && r.flags[B_POR];
	endproperty
	a_force_mon: assert property (p_force_mon) else $error("Monitor not forced on.");

	property p_pf_enter;
		(r.st == ST_RUN && mon_act && !r.s2[S_RST] && r.s2[S_POR]) |=> r.st == ST_SUPPLY_FAIL && o_core_rst;
	endproperty
	a_pf_enter: assert property (p_pf_enter) else $error("Supply fail not caught.");

	property p_sleep;
		(r.st == ST_RUN && i_sleep) |=> r.st != ST_SUPPLY_FAIL;
	endproperty
	a_sleep: assert property (p_sleep) else $error("Supply reset in sleep.");

	property p_warn;
		(r.warn_ie && !r.s2[S_WARN]) |=> o_warn_irq;
	endproperty
	a_warn: assert property (p_warn) else $error("Warning interrupt missing.");

	property p_flash;
		(i_flash_cmd && !r.mon_en) |=> !o_flash_go;
	endproperty
	a_flash: assert property (p_flash) else $error("Flash ran with monitor off.");

	c_por_exit: cover property ($past(r.st) == ST_POR_DELAY && r.st == ST_RUN);
	c_pf: cover property (r.st == ST_SUPPLY_FAIL ##[1:50] r.st == ST_RUN);
	c_sw: cover property (sw_req ##1 r.st == ST_HOLD);
	c_flash: cover property (o_flash_go);

endmodule : reset_supply_monitor
`default_nettype wire

// ==== core/reset_supply_monitor_pkg.sv ====
// Purpose: Constants and types for the reset and supply monitor block.
// Assumes: 40 MHz reference clock.
// Notes: Register offsets are byte addresses on the plain register port.
// How it works
// - Reset halts core, restores registers, disables interrupts.
// - RAM untouched by reset; stack pointer reset.
// - Ports latch 0xFF, open-drain, low drive, pullups.
// - Power-on and supply resets drive pin low.
// - Exit clears PC, enables watchdog, internal clock.
// - Power-on reset waits for supply above threshold.
// - Extra power-on delay after threshold is crossed.
// - Power-on flag set on leaving power-on reset.
// - Other flags undefined; other resets clear power-on flag.
// - Power-on and supply resets force monitor on.
// - Selected monitor holds reset while supply low.
// - After supply reset, flag reads one, RAM invalid.
// - Monitor state changes only by software or power.
// - Sleep suppresses supply resets, keeps RAM.
// - Wake restores software monitor settings.
// - Warning clears supply-ok bit, optional interrupt.
// - No flash erase or write with monitor off.
package reset_supply_monitor_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_POR_NS = 300000;
	localparam int POR_CYCLES = T_POR_NS / CLK_PERIOD_NS;
	localparam int HOLD_CYCLES = 4;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] CAUSE_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] MON_ADDR = 4'h4;
	// Cause register bit positions.
	localparam int B_PIN = 0;
	localparam int B_POR = 1;
	localparam int B_MCD = 2;
	localparam int B_WDT = 3;
	localparam int B_SW = 4;
	localparam int B_FERR = 6;
	localparam int B_RTC = 7;
	// Monitor register bit positions.
	localparam int M_EN = 7;
	localparam int M_OK = 6;
	localparam int M_SEL = 5;
	localparam int M_IE = 4;
	// Synchroniser lanes.
	localparam int S_PIN = 0;
	localparam int S_POR = 1;
	localparam int S_RST = 2;
	localparam int S_WARN = 3;
	localparam logic [3:0] SYNC_RST = 4'h1;
	localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
	localparam logic [15:0] BOOT_ADDR = 16'h0000;
	localparam logic [7:0] FLAGS_RST = 8'h02;

	typedef enum logic [2:0] {
		ST_POWER_UP,
		ST_POR_DELAY,
		ST_RUN,
		ST_SUPPLY_FAIL,
		ST_HOLD
	} rst_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic mcd;
		logic wdt;
		logic rtc;
		logic flash_err;
	} src_req_t;

	typedef struct packed {
		logic hold;
		logic [7:0] latch;
		logic push_pull;
		logic high_drive;
		logic pullup_en;
	} port_init_t;
endpackage : reset_supply_monitor_pkg

// ==== test/supply_rail_model.sv ====
// Purpose: Supply comparators and reset pin wire seen by the sequencer.
// Assumes: Level 0 below power-on, 1 below reset, 2 below warning, 3 good.
// Notes: The pin has a pull-up; any enabled driver pulls it low.
`timescale 1ns/1ps
`default_nettype none
module supply_rail_model (
	input wire logic [1:0] i_level,
	input wire logic i_ext_low,
	input wire logic i_pin_oe,
	output logic o_above_por,
	output logic o_above_rst,
	output logic o_above_warn,
	output logic o_pin_b
);
	// Comparator outputs follow the rail level.
	assign o_above_por = i_level >= 2'h1;
	assign o_above_rst = i_level >= 2'h2;
	assign o_above_warn = i_level == 2'h3;
	// Wired pin: pulled up unless the device or the board drives it low.
	assign o_pin_b = !(i_pin_oe || i_ext_low);
endmodule : supply_rail_model
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the reset and supply monitor.
// Assumes: Short power-on delay of 8 cycles for simulation speed.
// Notes: Random unmapped reads and flash requests mix with fixed cases.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import reset_supply_monitor_pkg::*;
;
	localparam int POR_D = 8;
	logic clk = 1'b0, rst_b = 1'b0, sleep = 1'b0, fcmd = 1'b0, ext_low = 1'b0;
	logic [1:0] lvl = 2'h1;
	reg_req_t rq = '0;
	src_req_t src = '0;
	logic [7:0] rdata, d;
	logic go, core_rst, pin_out, pin_oe, exit_p, irq, ram_lost, por_ok, rst_ok, warn_ok, pin_b;
	port_init_t port;
	logic [15:0] boot;
	int miscompares = 0, checks_done = 0, n, a;
	always #12.5 clk = ~clk;
	reset_supply_monitor #(.POR_DELAY_CYCLES(POR_D)) u_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_reg(rq),
		.o_rdata(rdata), .i_rst_pin_b(pin_b), .i_vdd_above_por(por_ok), .i_vdd_above_rst(rst_ok),
		.i_vdd_above_warn(warn_ok), .i_src(src), .i_sleep(sleep), .i_flash_cmd(fcmd), .o_flash_go(go),
		.o_core_rst(core_rst), .o_rst_pin_out(pin_out), .o_rst_pin_oe(pin_oe), .o_port(port),
		.o_exit_pulse(exit_p), .o_boot_addr(boot), .o_warn_irq(irq), .o_ram_lost(ram_lost));
	supply_rail_model u_rail (.i_level(lvl), .i_ext_low(ext_low), .i_pin_oe(pin_oe), .o_above_por(por_ok),
		.o_above_rst(rst_ok), .o_above_warn(warn_ok), .o_pin_b(pin_b));
	// Verdict and end of run.
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	// Compare one observed value with its expectation.
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Expected monitor register word from its four fields.
	function automatic logic [7:0] mon_word(input logic en, input logic ok, input logic sel, input logic ie);
		mon_word = 8'h00;
		mon_word[M_EN] = en;
		mon_word[M_OK] = ok;
		mon_word[M_SEL] = sel;
		mon_word[M_IE] = ie;
	endfunction : mon_word
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task wr(input logic [3:0] ad, input logic [7:0] wd);
		@(posedge clk) rq <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
		@(posedge clk) rq.wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] ad);
		@(posedge clk) rq <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk) rq.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task flash(input logic exp);
		@(posedge clk) fcmd <= 1'b1;
		@(posedge clk) fcmd <= 1'b0;
		#1 chk("flash_go", go, exp);
	endtask : flash
	// Bounded wait for the end of a reset; n counts the cycles taken.
	task wait_exit;
		n = 0;
		while (exit_p !== 1'b1 && n < 80) begin
			cyc(1);
			n++;
		end
		if (n >= 80) begin
			miscompares++;
			$display("[FAIL] exit_pulse expected 1 seen 0");
			final_report();
		end else begin
			chk("boot_addr", boot, BOOT_ADDR);
		end
	endtask : wait_exit
	initial begin
		void'($urandom(1));
		cyc(10);
		chk("core_rst", core_rst, 1'b1);
		chk("pin_oe", {pin_oe, pin_out}, 2'h2);
		chk("port", port, {1'b1, PORT_LATCH_RST, 3'h1});
		@(posedge clk) rst_b <= 1'b1;
		cyc(20);
		chk("held_below_threshold", core_rst, 1'b1);
		@(posedge clk) lvl <= 2'h3;
		wait_exit();
		chk("por_delay", n >= POR_D && n <= POR_D + 6, 1'b1);
		rd(CAUSE_ADDR);
		chk("cause_por", d, FLAGS_RST);
		rd(MON_ADDR);
		chk("mon_por", d, 8'hE0);
		$display("test power_on done");
		// Reset sources other than the supply leave the pin alone.
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) begin
				// Missing clock, watchdog, flash error, then the pin alone.
				src <= src_req_t'((i == 0) ? 4'h8 : (i == 1) ? 4'h4 : (i == 2) ? 4'h1 : 4'h0);
				ext_low <= (i == 3);
			end
			@(posedge clk) src <= '0;
			cyc(3);
			ext_low <= 1'b0;
			chk("src_reset", {core_rst, pin_oe}, 2'h2);
			wait_exit();
			rd(CAUSE_ADDR);
			chk("cause_src", d, 8'h01 << ((i == 0) ? B_MCD : (i == 1) ? B_WDT : (i == 2) ? B_FERR : B_PIN));
		end
		$display("test sources done");
		wr(MON_ADDR, 8'h00);
		wr(CAUSE_ADDR, 8'h00);
		// The reset write itself leaves the selection as it stands.
		wr(CAUSE_ADDR, 8'h10);
		wait_exit();
		rd(MON_ADDR);
		chk("mon_after_sw", d, mon_word(1'b0, 1'b1, 1'b0, 1'b0));
		flash(1'b0);
		@(posedge clk) lvl <= 2'h1;
		cyc(10);
		chk("fail_ignored", core_rst, 1'b0);
		@(posedge clk) lvl <= 2'h3;
		wr(MON_ADDR, 8'h90);
		wr(CAUSE_ADDR, 8'h02);
		flash(1'b1);
		@(posedge clk) lvl <= 2'h2;
		cyc(4);
		rd(MON_ADDR);
		chk("warn", {d, irq}, {8'hB0, 1'b1});
		@(posedge clk) begin
			lvl <= 2'h1;
			sleep <= 1'b1;
		end
		cyc(20);
		chk("sleep_no_reset", core_rst, 1'b0);
		@(posedge clk) lvl <= 2'h3;
		cyc(4);
		sleep <= 1'b0;
		rd(MON_ADDR);
		chk("mon_wake", d, mon_word(1'b1, 1'b1, 1'b1, 1'b1));
		$display("test monitor done");
		@(posedge clk) lvl <= 2'h1;
		cyc(5);
		chk("fail_reset", {core_rst, pin_oe}, 2'h3);
		@(posedge clk) lvl <= 2'h3;
		wait_exit();
		rd(CAUSE_ADDR);
		chk("fail_flags", {d[1], ram_lost}, 2'h3);
		rd(MON_ADDR);
		chk("mon_fail", d, 8'hE0);
		wr(MON_ADDR, 8'h00);
		wr(CAUSE_ADDR, 8'h00);
		@(posedge clk) lvl <= 2'h0;
		cyc(5);
		@(posedge clk) lvl <= 2'h3;
		wait_exit();
		rd(MON_ADDR);
		chk("mon_repower", d, 8'hE0);
		$display("test power_fail done");
		// Random unmapped reads and writes, plus flash requests.
		for (int i = 0; i < 20; i++) begin
			a = $urandom_range(15);
			if (a == 0 || a == 4) a++;
			wr(a[3:0], 8'($urandom));
			rd(a[3:0]);
			chk("unmapped", d, 8'h00);
			flash(1'b1);
		end
		rd(MON_ADDR);
		chk("mon_kept", d, 8'hE0);
		$display("test random done");
		final_report();
	end
endmodule : testbench
`default_nettype wire
